// ### hdl/pxbar_map.svh
/*
  constants of the port crossbar block: register addresses, field positions,
  reset values and peripheral signal indices in priority order.
  assumes an 8-bit special-function-register address space.
*/
`ifndef PXBAR_MAP_SVH
`define PXBAR_MAP_SVH

// register addresses
`define PXB_ADDR_P0_LATCH 8'h80
`define PXB_ADDR_P1_LATCH 8'h90
`define PXB_ADDR_P0_MODE 8'ha4
`define PXB_ADDR_P1_MODE 8'ha5
`define PXB_ADDR_P1_ANALOG 8'had
`define PXB_ADDR_ROUTE_A 8'he1
`define PXB_ADDR_ROUTE_B 8'he2
`define PXB_ADDR_ROUTE_C 8'he3
`define PXB_ADDR_ROUTE_D 8'he4

// reset values
`define PXB_RST_LATCH 8'hff
`define PXB_RST_MODE 8'h00
`define PXB_RST_ANALOG 8'hff
`define PXB_RST_ROUTE 8'h00

// writable masks
`define PXB_WMASK_ROUTE_C 8'hdf
`define PXB_WMASK_ROUTE_D 8'h8f

// field positions
`define PXB_A_CMP0 7
`define PXB_A_ECI 6
`define PXB_A_CEX_HI 5
`define PXB_A_CEX_LO 3
`define PXB_A_SER_A 2
`define PXB_A_SYNC 1
`define PXB_A_TWO_WIRE 0
`define PXB_C_PUD 7
`define PXB_C_XBAR 6
`define PXB_C_T4EX 4
`define PXB_C_T4 3
`define PXB_C_SER_B 2
`define PXB_C_MEMIF_LOW 1
`define PXB_C_CONV0 0
`define PXB_D_CAN_PP 7
`define PXB_D_CMP2 3
`define PXB_D_CONV2 2
`define PXB_D_T3EX 1
`define PXB_D_T3 0

// peripheral signals, highest priority first
`define PXB_SIG_N 33
`define PXB_SIG_SER_A_RX 1
`define PXB_SIG_NSS 5
`define PXB_SIG_SDA 6
`define PXB_SIG_SCL 7
`define PXB_SIG_SER_B_RX 9
`define PXB_SIG_COUNTER_MODULE0_OUTPUT 10
`define PXB_CEX_N 6
`define PXB_SIG_BASE_B 16

`define PXB_PINS 16

`endif

// ### hdl/pxbar_pkg.sv
/*
  types of the port crossbar block.
  assumes pxbar_map.svh is on the include path.
*/
`default_nettype none
`include "pxbar_map.svh"

package pxbar_pkg;

  typedef struct packed {
    logic [7:0] p0Latch;
    logic [7:0] p1Latch;
    logic [7:0] p0Mode;
    logic [7:0] p1Mode;
    logic [7:0] p1Analog;
    logic [7:0] routeA;
    logic [7:0] routeB;
    logic [7:0] routeC;
    logic [7:0] routeD;
  } pxbar_regs_s;

  typedef struct packed {
    logic [`PXB_PINS-1:0] out;
    logic [`PXB_PINS-1:0] oe;
    logic [`PXB_PINS-1:0] pullupEn;
  } pxbar_pins_s;

  typedef struct packed {
    pxbar_regs_s regs;
    logic [`PXB_PINS-1:0] syncA;
    logic [`PXB_PINS-1:0] syncB;
    logic [`PXB_PINS-1:0] assigned;
    logic [7:0] rdData;
    pxbar_pins_s pins;
    logic [`PXB_SIG_N-1:0] periphIn;
    logic canTxOut;
    logic canTxOe;
  } pxbar_state_s;

endpackage

`default_nettype wire

// ### hdl/pxbar_core.sv
/*
  port crossbar: routing registers, port 0/1 latches and drive modes, priority
  assignment of peripheral signals onto the 16 pins of ports 0 and 1, pin drive,
  weak pull-ups and pin read-back.
  assumes the cpu register bus, peripherals and memory interface run on clk;
  pin levels arrive asynchronously; the pad resolves out/oe and the pull-up.
*/
// Behaviour
// - counter field value N routes capture modules 0..N-1 onto N pins; value 7 routes the same six modules as 6
// - first serial port bit puts transmit on port0 pin0, receive on pin1
// - sync serial bit routes four signals; select line omitted in three-wire mode
// - two-wire bit routes data and clock; clear means neither reaches a pin
// - first register bit7 routes comparator 0, bit6 routes counter input
// - second register bits route inverted_system_clock, timers, interrupts and comparator 1
// - pull-up disable bit one turns all weak pull-ups off
// - crossbar enable clear forces every pin to input
// - third register bit5 reads zero, writes ignored
// - third register routes timer 4 inputs, second serial port, converter 0 start
// - low-port bit clear leaves port0 pins 5..7 to crossbar or latches
// - low-port set, multiplexed memory mode: pins 7,6,5 skipped
// - low-port set, non-multiplexed mode: only pins 7,6 skipped
// - can transmit mode bit: 0 open-drain, 1 push-pull
// - fourth register routes comparator 2, converter 2, timer 3; bits 6..4 read-only
// - latch 0 drives low, 1 drives high only in push-pull
// - port data read returns pin levels regardless of routing
// - port0 drive mode bit: 0 open-drain, 1 push-pull
// - two-wire pins and mode-0 serial receive pins always open-drain
// - analog port1 pins skipped, digital input off, driver follows latch
// - non-multiplexed memory mode may drive port1 as high address
// - signals take the next non-skipped pin in fixed priority order
// - analog pin reads zero and has its pull-up off
`timescale 1ns/10ps
`default_nettype none
`include "pxbar_map.svh"

module pxbar_core #(
  parameter int unsigned PORT_PINS = 16
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic sfrWr,
  input wire logic sfrRd,
  input wire logic [7:0] sfrAddr,
  input wire logic [7:0] sfrWdata,
  output logic [7:0] sfrRdata,
  input wire logic [`PXB_PINS-1:0] pinIn,
  output logic [`PXB_PINS-1:0] pinOut,
  output logic [`PXB_PINS-1:0] pinOe,
  output logic [`PXB_PINS-1:0] pinPullupEn,
  input wire logic [`PXB_SIG_N-1:0] periphOut,
  input wire logic [`PXB_SIG_N-1:0] periphDrive,
  output logic [`PXB_SIG_N-1:0] periphIn,
  input wire logic spiThreeWire,
  input wire logic serialAMode0,
  input wire logic serialBMode0,
  input wire logic memifNonmuxSelect,
  input wire logic memifActive,
  input wire logic [2:0] memifCtrlOut,
  input wire logic [7:0] memifAddrHigh,
  input wire logic canTxValue,
  output logic canTxOut,
  output logic canTxOe
);

  if (PORT_PINS != `PXB_PINS) begin : gBadPins
    $error("pxbar_core serves exactly 16 port pins");
  end

  pxbar_pkg::pxbar_state_s st_q;
  pxbar_pkg::pxbar_state_s st_d;

  ////////////////////////////////////////////////////////////////////////////
  // peripheral enables in priority order

  logic [`PXB_SIG_N-1:0] sigEn;
  logic [7:0] rA;
  logic [7:0] rB;
  logic [7:0] rC;
  logic [7:0] rD;

  assign rA = st_q.regs.routeA;
  assign rB = st_q.regs.routeB;
  assign rC = st_q.regs.routeC;
  assign rD = st_q.regs.routeD;

  assign sigEn[1:0] = {2{rA[`PXB_A_SER_A]}};
  assign sigEn[4:2] = {3{rA[`PXB_A_SYNC]}};
  assign sigEn[`PXB_SIG_NSS] = rA[`PXB_A_SYNC] & ~spiThreeWire;
  assign sigEn[`PXB_SIG_SCL:`PXB_SIG_SDA] = {2{rA[`PXB_A_TWO_WIRE]}};
  assign sigEn[9:8] = {2{rC[`PXB_C_SER_B]}};

  genvar gi;
  for (gi = 0; gi < `PXB_CEX_N; gi++) begin : gCex
    assign sigEn[`PXB_SIG_COUNTER_MODULE0_OUTPUT+gi] = (rA[`PXB_A_CEX_HI:`PXB_A_CEX_LO] > 3'(gi));
  end

  assign sigEn[16] = rA[`PXB_A_ECI];
  assign sigEn[17] = rA[`PXB_A_CMP0];
  // comparator 1, timer 0, int 0, timer 1, int 1, timer 2, timer 2 ext
  assign sigEn[24:18] = rB[6:0];
  assign sigEn[25] = rC[`PXB_C_T4];
  assign sigEn[26] = rC[`PXB_C_T4EX];
  assign sigEn[27] = rB[7];
  assign sigEn[28] = rC[`PXB_C_CONV0];
  assign sigEn[29] = rD[`PXB_D_T3];
  assign sigEn[30] = rD[`PXB_D_T3EX];
  assign sigEn[31] = rD[`PXB_D_CMP2];
  assign sigEn[32] = rD[`PXB_D_CONV2];

  ////////////////////////////////////////////////////////////////////////////
  // next state

  always_comb begin
    logic [`PXB_SIG_N-1:0] rem;
    logic [`PXB_PINS-1:0] skip;
    logic [`PXB_PINS-1:0] pinRead;
    logic [`PXB_PINS-1:0] latch;
    logic [`PXB_PINS-1:0] mode;
    logic [5:0] sel;
    logic found;
    logic xbar;
    logic lowPort;
    logic drv;
    logic val;
    logic forceOd;
    rem = sigEn;
    skip = '0;
    pinRead = '0;
    latch = {st_q.regs.p1Latch, st_q.regs.p0Latch};
    mode = {st_q.regs.p1Mode, st_q.regs.p0Mode};
    sel = '0;
    found = 1'b0;
    xbar = rC[`PXB_C_XBAR];
    lowPort = rC[`PXB_C_MEMIF_LOW];
    drv = 1'b0;
    val = 1'b0;
    forceOd = 1'b0;
    st_d = st_q;

    // register writes take effect on the next edge
    if (sfrWr) begin
      case (sfrAddr)
        `PXB_ADDR_P0_LATCH: st_d.regs.p0Latch = sfrWdata;
        `PXB_ADDR_P1_LATCH: st_d.regs.p1Latch = sfrWdata;
        `PXB_ADDR_P0_MODE: st_d.regs.p0Mode = sfrWdata;
        `PXB_ADDR_P1_MODE: st_d.regs.p1Mode = sfrWdata;
        `PXB_ADDR_P1_ANALOG: st_d.regs.p1Analog = sfrWdata;
        `PXB_ADDR_ROUTE_A: st_d.regs.routeA = sfrWdata;
        `PXB_ADDR_ROUTE_B: st_d.regs.routeB = sfrWdata;
        `PXB_ADDR_ROUTE_C: st_d.regs.routeC = sfrWdata & `PXB_WMASK_ROUTE_C;
        `PXB_ADDR_ROUTE_D: st_d.regs.routeD = sfrWdata & `PXB_WMASK_ROUTE_D;
        default: st_d.regs = st_q.regs;
      endcase
    end

    // pin synchronisers; analog port1 pins read zero
    st_d.syncA = pinIn;
    st_d.syncB = st_q.syncA;
    pinRead = st_q.syncB & {st_q.regs.p1Analog, 8'hff};

    // pin skipping
    skip[7] = lowPort;
    skip[6] = lowPort;
    skip[5] = lowPort & ~memifNonmuxSelect;
    skip[15:8] = ~st_q.regs.p1Analog;

    st_d.periphIn = '1;
    for (int p = 0; p < `PXB_PINS; p++) begin
      found = 1'b0;
      sel = '0;
      if (!skip[p]) begin
        for (int s = 0; s < `PXB_SIG_N; s++) begin
          if (!found && rem[s]) begin
            found = 1'b1;
            sel = 6'(s);
          end
        end
      end
      if (found) begin
        rem[sel] = 1'b0;
      end
      found = found & xbar;
      st_d.assigned[p] = found;

      // drive source: routed peripheral, memory interface or latch
      drv = 1'b1;
      val = latch[p];
      forceOd = 1'b0;
      if (found) begin
        drv = periphDrive[sel];
        val = periphOut[sel];
        st_d.periphIn[sel] = st_q.syncB[p];
        forceOd = (sel == 6'(`PXB_SIG_SDA)) || (sel == 6'(`PXB_SIG_SCL)) ||
                  (sel == 6'(`PXB_SIG_SER_A_RX) && serialAMode0) ||
                  (sel == 6'(`PXB_SIG_SER_B_RX) && serialBMode0);
      end else if (memifActive && skip[p] && p >= 5 && p < 8) begin
        val = memifCtrlOut[p-5];
      end else if (memifActive && memifNonmuxSelect && p >= 8) begin
        val = memifAddrHigh[p-8];
      end
      st_d.pins.out[p] = val;
      st_d.pins.oe[p] = xbar & drv & (~val | (mode[p] & ~forceOd));
    end

    st_d.pins.pullupEn = {PORT_PINS{~rC[`PXB_C_PUD]}} & {st_q.regs.p1Analog, 8'hff};

    st_d.canTxOut = canTxValue;
    st_d.canTxOe = ~canTxValue | rD[`PXB_D_CAN_PP];

    // read data; unmapped addresses read zero
    st_d.rdData = st_q.rdData;
    if (sfrRd) begin
      case (sfrAddr)
        `PXB_ADDR_P0_LATCH: st_d.rdData = pinRead[7:0];
        `PXB_ADDR_P1_LATCH: st_d.rdData = pinRead[15:8];
        `PXB_ADDR_P0_MODE: st_d.rdData = st_q.regs.p0Mode;
        `PXB_ADDR_P1_MODE: st_d.rdData = st_q.regs.p1Mode;
        `PXB_ADDR_P1_ANALOG: st_d.rdData = st_q.regs.p1Analog;
        `PXB_ADDR_ROUTE_A: st_d.rdData = rA;
        `PXB_ADDR_ROUTE_B: st_d.rdData = rB;
        `PXB_ADDR_ROUTE_C: st_d.rdData = rC;
        `PXB_ADDR_ROUTE_D: st_d.rdData = rD;
        default: st_d.rdData = 8'h00;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // state register

  always_ff @(posedge clk) begin
    if (srst) begin
      st_q.regs.p0Latch <= `PXB_RST_LATCH;
      st_q.regs.p1Latch <= `PXB_RST_LATCH;
      st_q.regs.p0Mode <= `PXB_RST_MODE;
      st_q.regs.p1Mode <= `PXB_RST_MODE;
      st_q.regs.p1Analog <= `PXB_RST_ANALOG;
      st_q.regs.routeA <= `PXB_RST_ROUTE;
      st_q.regs.routeB <= `PXB_RST_ROUTE;
      st_q.regs.routeC <= `PXB_RST_ROUTE;
      st_q.regs.routeD <= `PXB_RST_ROUTE;
      st_q.syncA <= '0;
      st_q.syncB <= '0;
      st_q.assigned <= '0;
      st_q.rdData <= 8'h00;
      st_q.pins.out <= '1;
      st_q.pins.oe <= '0;
      st_q.pins.pullupEn <= '1;
      st_q.periphIn <= '1;
      st_q.canTxOut <= 1'b1;
      st_q.canTxOe <= 1'b0;
    end else begin
      st_q <= st_d;
    end
  end

  assign sfrRdata = st_q.rdData;
  assign pinOut = st_q.pins.out;
  assign pinOe = st_q.pins.oe;
  assign pinPullupEn = st_q.pins.pullupEn;
  assign periphIn = st_q.periphIn;
  assign canTxOut = st_q.canTxOut;
  assign canTxOe = st_q.canTxOe;

  ////////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  AST_XBAR_OFF_INPUT: assert property (
    !rC[`PXB_C_XBAR] |=> (pinOe == '0)
  ) else $error("pin driven while crossbar disabled");

  AST_PULLUP_DISABLE: assert property (
    rC[`PXB_C_PUD] |=> (pinPullupEn == '0)
  ) else $error("pull-up on while globally disabled");

  AST_ANALOG_PULLUP: assert property (
    1'b1 |=> ((pinPullupEn[15:8] & ~$past(st_q.regs.p1Analog)) == 8'h00)
  ) else $error("analog pin has pull-up enabled");

  AST_SER_A_PIN0: assert property (
    (rC[`PXB_C_XBAR] && rA[`PXB_A_SER_A] && periphDrive[0]) |=> (pinOut[0] == $past(periphOut[0]))
  ) else $error("serial transmit not on port0 pin0");

  AST_TWO_WIRE_OFF: assert property (
    !rA[`PXB_A_TWO_WIRE] |=> (periphIn[`PXB_SIG_SDA] && periphIn[`PXB_SIG_SCL])
  ) else $error("two-wire signal routed while disabled");

  AST_UNUSED_BIT_ZERO: assert property (
    rC[5] == 1'b0
  ) else $error("unused routing bit not zero");

  AST_RESERVED_ZERO: assert property (
    rD[6:4] == 3'h0
  ) else $error("reserved routing bits not zero");

  AST_CAN_DRIVE: assert property (
    1'b1 |=> (canTxOe == (!$past(canTxValue) || $past(rD[`PXB_D_CAN_PP])))
  ) else $error("can transmit drive mode wrong");

  AST_MUX_SKIP: assert property (
    (rC[`PXB_C_MEMIF_LOW] && !memifNonmuxSelect) |=> (st_q.assigned[7:5] == 3'h0)
  ) else $error("memory interface pins not skipped");

  AST_PIN_READ: assert property (
    (sfrRd && sfrAddr == `PXB_ADDR_P0_LATCH) |=> (sfrRdata == $past(st_q.syncB[7:0]))
  ) else $error("port read not pin level");

  AST_WRITE_UPDATE: assert property (
    (sfrWr && sfrAddr == `PXB_ADDR_ROUTE_B) |=> (rB == $past(sfrWdata))
  ) else $error("routing register write lost");

  AST_NSS_THREE_WIRE: assert property (
    (rA[`PXB_A_SYNC] && spiThreeWire) |=> periphIn[`PXB_SIG_NSS]
  ) else $error("select line routed in three-wire mode");

  AST_CEX_NONE: assert property (
    (rA[`PXB_A_CEX_HI:`PXB_A_CEX_LO] == 3'h0) |=> (periphIn[`PXB_SIG_COUNTER_MODULE0_OUTPUT +: `PXB_CEX_N] == 6'h3f)
  ) else $error("capture module routed while field is zero");

  AST_HIGH_NEEDS_PP: assert property (
    1'b1 |=> ((pinOe & pinOut & ~{$past(st_q.regs.p1Mode), $past(st_q.regs.p0Mode)}) == 16'h0000)
  ) else $error("open-drain pin driven high");

  AST_ANALOG_READ_ZERO: assert property (
    (sfrRd && sfrAddr == `PXB_ADDR_P1_LATCH) |=> ((sfrRdata & ~$past(st_q.regs.p1Analog)) == 8'h00)
  ) else $error("analog pin read not zero");

  AST_XBAR_OFF_PERIPH: assert property (
    !rC[`PXB_C_XBAR] |=> (periphIn == '1 && st_q.assigned == '0)
  ) else $error("peripheral routed while crossbar disabled");

  AST_TWO_WIRE_OD: assert property (
    (rC[`PXB_C_XBAR] && rA[`PXB_A_TWO_WIRE] && !rA[`PXB_A_SER_A] && !rA[`PXB_A_SYNC])
      |=> !(pinOe[0] && pinOut[0]) && !(pinOe[1] && pinOut[1])
  ) else $error("two-wire pin driven high");

  COV_XBAR_ON: cover property (sfrWr && sfrAddr == `PXB_ADDR_ROUTE_C && sfrWdata[`PXB_C_XBAR]);
  COV_SKIP_P1: cover property (rC[`PXB_C_XBAR] && st_q.assigned[8] && st_q.regs.p1Analog != 8'hff);
  COV_ALL_CEX: cover property (rA[`PXB_A_CEX_HI:`PXB_A_CEX_LO] == 3'h6 && rC[`PXB_C_XBAR]);
  COV_PIN_READ: cover property (sfrRd && sfrAddr == `PXB_ADDR_P1_LATCH);

endmodule

`default_nettype wire

// ### verification/pxbar_pad_model.sv
/*
  pad model: resolves each pin from the core drive, outside drivers and the weak pull-up.
  assumes outside drivers give way while the core drives a pin.
*/
`timescale 1ns/10ps
`default_nettype none

module pxbar_pad_model (
  input wire logic clk,
  input wire logic [15:0] pinOut,
  input wire logic [15:0] pinOe,
  input wire logic [15:0] pinPullupEn,
  input wire logic [15:0] extEn,
  input wire logic [15:0] extVal,
  output logic [15:0] pad
);
  logic [15:0] flt_q = 16'h5a5a;

  // a floating pin changes every cycle
  always @(posedge clk) flt_q <= ~flt_q;

  always_comb begin
    for (int i = 0; i < 16; i++) begin
      pad[i] = pinOe[i] ? pinOut[i] : extEn[i] ? extVal[i] : pinPullupEn[i] ? 1'b1 : flt_q[i];
    end
  end
endmodule

`default_nettype wire

// ### verification/port_crossbar_routing_control_test.sv
/*
  self-checking bench of the port crossbar: random register and peripheral setups
  compared with a priority model of the pin assignment.
  assumes pxbar_core and pxbar_pad_model are compiled first.
*/
`timescale 1ns/10ps
`default_nettype none

module port_crossbar_routing_control_test;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic sfrWr = 1'b0;
  logic sfrRd = 1'b0;
  logic [7:0] sfrAddr = 8'h00;
  logic [7:0] sfrWdata = 8'h00;
  logic [7:0] sfrRdata, d, l0, l1;
  logic [15:0] pad, pinOut, pinOe, pinPullupEn, eOe, eOut, ePu;
  logic [15:0] extEn = 16'h0000;
  logic [15:0] extVal = 16'h0000;
  logic [32:0] periphOut = '0;
  logic [32:0] periphDrive = '0;
  logic [32:0] periphIn, eIn;
  // three-wire, mode 0 a, mode 0 b, non-multiplexed, memory active
  logic [4:0] lv = 5'h00;
  logic [2:0] memifCtrlOut = 3'h0;
  logic [7:0] memifAddrHigh = 8'h00;
  logic canTxValue = 1'b0;
  logic canTxOut, canTxOe;
  logic [7:0] m [7];
  int sig [16];
  int nFail = 0;
  int checks = 0;
  int cyc = 0;
  localparam logic [55:0] AD = 56'ha4a5ade1e2e3e4;
  localparam logic [55:0] MK = 56'hffffffffffdf8f;
  localparam logic [55:0] RV = 56'h0000ff00000000;

  pxbar_core i_pxbar_core (
    .clk(clk), .srst(srst), .sfrWr(sfrWr), .sfrRd(sfrRd), .sfrAddr(sfrAddr), .sfrWdata(sfrWdata),
    .sfrRdata(sfrRdata), .pinIn(pad), .pinOut(pinOut), .pinOe(pinOe), .pinPullupEn(pinPullupEn),
    .periphOut(periphOut), .periphDrive(periphDrive), .periphIn(periphIn), .spiThreeWire(lv[0]),
    .serialAMode0(lv[1]), .serialBMode0(lv[2]), .memifNonmuxSelect(lv[3]), .memifActive(lv[4]),
    .memifCtrlOut(memifCtrlOut), .memifAddrHigh(memifAddrHigh), .canTxValue(canTxValue),
    .canTxOut(canTxOut), .canTxOe(canTxOe)
  );

  pxbar_pad_model i_pxbar_pad_model (
    .clk(clk), .pinOut(pinOut), .pinOe(pinOe), .pinPullupEn(pinPullupEn),
    .extEn(extEn), .extVal(extVal), .pad(pad)
  );

  always #25 clk = ~clk;

  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      nFail++;
      finish_test();
    end
  end

  ////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [32:0] e, input logic [32:0] g);
    checks++;
    if (g !== e) begin
      nFail++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic chkReg(input string nm, input logic [7:0] e, input logic [7:0] g);
    chk(nm, {25'h0, e}, {25'h0, g});
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(negedge clk);
    sfrRd = 1'b0;
    sfrWr = 1'b1;
    sfrAddr = a;
    sfrWdata = v;
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    @(negedge clk);
    sfrWr = 1'b0;
    sfrRd = 1'b1;
    sfrAddr = a;
    @(negedge clk);
    sfrRd = 1'b0;
    v = sfrRdata;
  endtask

  ////////////////////////////////////////////////////////////
  task automatic model();
    logic [32:0] en;
    logic [7:0] a, b, c;
    logic v, md, fod, sk;
    int q [$];
    int s;
    a = m[3];
    b = m[4];
    c = m[5];
    en = '0;
    en[1:0] = {2{a[2]}};
    en[4:2] = {3{a[1]}};
    en[5] = a[1] & !lv[0];
    en[7:6] = {2{a[0]}};
    en[9:8] = {2{c[2]}};
    for (int i = 0; i < 6; i++) en[10+i] = (i < a[5:3]);
    en[17:16] = {a[7], a[6]};
    en[24:18] = b[6:0];
    en[28:25] = {c[0], b[7], c[4], c[3]};
    en[32:29] = {m[6][2], m[6][3], m[6][1], m[6][0]};
    if (!c[6]) en = '0;
    for (int i = 0; i < 33; i++) if (en[i]) q.push_back(i);
    for (int p = 0; p < 16; p++) begin
      sk = (p > 4 && p < 8 && c[1] && (p > 5 || !lv[3])) || (p > 7 && !m[2][p%8]);
      sig[p] = (sk || q.size() == 0) ? -1 : q.pop_front();
      md = (p < 8) ? m[0][p%8] : m[1][p%8];
      s = sig[p];
      if (s >= 0) begin
        v = periphOut[s];
        fod = (s == 6) || (s == 7) || (s == 1 && lv[1]) || (s == 9 && lv[2]);
        eOe[p] = periphDrive[s] & (!v | (md & !fod));
      end else begin
        v = (p < 8) ? l0[p%8] : l1[p%8];
        if (lv[4] && p < 8 && sk) v = memifCtrlOut[p-5];
        if (lv[4] && lv[3] && p > 7) v = memifAddrHigh[p%8];
        eOe[p] = c[6] & (!v | md);
      end
      eOut[p] = v;
      ePu[p] = !c[7] & (p < 8 || m[2][p%8]);
    end
  endtask

  task automatic chkPins();
    logic [15:0] kn;
    logic [32:0] ms;
    repeat (6) @(negedge clk);
    model();
    kn = eOe | extEn | ePu;
    eIn = '1;
    ms = '1;
    for (int p = 0; p < 16; p++) begin
      if (sig[p] >= 0) eIn[sig[p]] = pad[p];
      if (sig[p] >= 0 && !kn[p]) ms[sig[p]] = 1'b0;
    end
    chk("pinOe", {17'h0, eOe}, {17'h0, pinOe});
    chk("pinOut", {17'h0, eOut & eOe}, {17'h0, pinOut & pinOe});
    chk("pinPullupEn", {17'h0, ePu}, {17'h0, pinPullupEn});
    chk("periphIn", eIn & ms, periphIn & ms);
    chk("canTxOe", {32'h0, !canTxValue | m[6][7]}, {32'h0, canTxOe});
    chk("canTxOut", {32'h0, canTxValue}, {32'h0, canTxOut});
    rd(8'h80, d);
    chkReg("port0", pad[7:0] & kn[7:0], d & kn[7:0]);
    kn[15:8] = kn[15:8] | ~m[2];
    rd(8'h90, d);
    chkReg("port1", pad[15:8] & m[2] & kn[15:8], d & kn[15:8]);
  endtask

  task automatic rstChk();
    srst = 1'b1;
    repeat (20) @(negedge clk);
    srst = 1'b0;
    l0 = 8'hff;
    l1 = 8'hff;
    for (int i = 0; i < 7; i++) begin
      m[i] = RV[8*(6-i) +: 8];
      rd(AD[8*(6-i) +: 8], d);
      chkReg("reset value", m[i], d);
    end
    chkPins();
  endtask

  task automatic finish_test();
    $display("checks %0d nFail %0d", checks, nFail);
    if (nFail == 0 && checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////
  initial begin
    void'($urandom(39));
    rstChk();
    repeat (60) begin
      @(negedge clk);
      periphOut = {1'($urandom), $urandom};
      periphDrive = {1'($urandom), $urandom};
      extEn = 16'($urandom);
      extVal = 16'($urandom);
      lv = 5'($urandom);
      memifCtrlOut = 3'($urandom);
      memifAddrHigh = 8'($urandom);
      canTxValue = 1'($urandom);
      for (int i = 0; i < 7; i++) begin
        d = 8'($urandom);
        if (i == 5 && $urandom % 4 != 0) d[6] = 1'b1;
        if (i == 2 && $urandom % 2 != 0) d = 8'hff;
        m[i] = d & MK[8*(6-i) +: 8];
        wr(AD[8*(6-i) +: 8], d);
      end
      l0 = 8'($urandom);
      l1 = 8'($urandom);
      wr(8'h80, l0);
      wr(8'h90, l1);
      for (int i = 0; i < 7; i++) begin
        rd(AD[8*(6-i) +: 8], d);
        chkReg("register", m[i], d);
      end
      rd(8'hc0, d);
      chkReg("unmapped", 8'h00, d);
      chkPins();
    end
    rstChk();
    finish_test();
  end
endmodule

`default_nettype wire
